// ===== src/peripheral_interrupt_mask.sv
// Peripheral interrupt mask: per-source enables feeding grouped interrupt lines
//
// The address-and-strobe port was chosen for this implementation.
`include "pirq_map.svh"

// Operation
// - Mask register individually enables peripheral, serial and timer-wrap group sources.
// - Bit 2 set lets timer 2 wrap request the timer group line.
// - Bit 0 set lets timer 1 wrap request the shared timer group line.
// - Timer group line delivered only while main mask bit 0 is set.
module peripheral_interrupt_mask
    import pirq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [`DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [`DATA_W-1:0] rdata_out,
    input wire logic timer1_wrap_in,
    input wire logic timer2_wrap_in,
    input wire logic periph_event_in,
    input wire logic serial_event_in,
    output logic timer_wrap_group_irq_out,
    output logic peripheral_group_irq_out,
    output logic serial_group_irq_out,
    output logic irq_out
);
    // Synchronised pin levels and their previous values
    logic t1_lvl;
    logic t2_lvl;
    logic pe_lvl;
    logic se_lvl;
    logic t1_prev_ff;
    logic t2_prev_ff;
    logic pe_prev_ff;
    logic se_prev_ff;

    // Bus registers and their next values
    reg8_t peripheral_irq_enable_ff;
    reg8_t nxt_peripheral_irq_enable;
    reg8_t pending_ff;
    reg8_t nxt_pending;
    reg8_t main_enable_ff;
    reg8_t nxt_main_enable;
    reg8_t evt_status_ff;
    reg8_t nxt_evt_status;
    reg8_t evt_mask_ff;
    reg8_t nxt_evt_mask;
    reg8_t rdata_ff;
    reg8_t nxt_rdata;
    logic timer_grp_ff;
    logic nxt_timer_grp;
    logic periph_grp_ff;
    logic nxt_periph_grp;
    logic serial_grp_ff;
    logic nxt_serial_grp;
    logic irq_ff;
    logic nxt_irq;

    reg8_t rise;
    reg8_t gated;
    logic timer_req;
    logic periph_req;
    logic serial_req;
    reg8_t grp_evt;
    // Next-value copies of the edge-detect history
    logic nxt_t1_prev;
    logic nxt_t2_prev;
    logic nxt_pe_prev;
    logic nxt_se_prev;
    // Write decodes, one per mapped register
    logic wr_enable_hit;
    logic wr_pending_hit;
    logic wr_main_hit;
    logic wr_status_hit;
    logic wr_evt_mask_hit;

    // Exact address match; unmapped writes fall through untouched
    assign wr_enable_hit = wr_in && (addr_in == `PERIPHERAL_IRQ_ENABLE_OFS);
    assign wr_pending_hit = wr_in && (addr_in == `PERIPHERAL_IRQ_PENDING_OFS);
    assign wr_main_hit = wr_in && (addr_in == `MAIN_IRQ_ENABLE_OFS);
    assign wr_status_hit = wr_in && (addr_in == `EVENT_STATUS_OFS);
    assign wr_evt_mask_hit = wr_in && (addr_in == `EVENT_MASK_OFS);

    pin_sync u_sync_t1 (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(timer1_wrap_in),
        .level_out(t1_lvl)
    );
    pin_sync u_sync_t2 (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(timer2_wrap_in),
        .level_out(t2_lvl)
    );
    pin_sync u_sync_pe (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(periph_event_in),
        .level_out(pe_lvl)
    );
    pin_sync u_sync_se (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(serial_event_in),
        .level_out(se_lvl)
    );

    // Edge detect on synchronised levels; reset low matches idle pins
    always_comb
    begin
        nxt_t1_prev = t1_lvl;
        nxt_t2_prev = t2_lvl;
        nxt_pe_prev = pe_lvl;
        nxt_se_prev = se_lvl;
        rise = 8'h00;
        rise[`TIMER1_WRAP_BIT] = t1_lvl & ~t1_prev_ff;
        rise[`TIMER2_WRAP_BIT] = t2_lvl & ~t2_prev_ff;
        rise[`PERIPH_SRC_BIT] = pe_lvl & ~pe_prev_ff;
        rise[`SERIAL_SRC_BIT] = se_lvl & ~se_prev_ff;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            t1_prev_ff <= 1'b0;
            t2_prev_ff <= 1'b0;
            pe_prev_ff <= 1'b0;
            se_prev_ff <= 1'b0;
        end
        else
        begin
            t1_prev_ff <= nxt_t1_prev;
            t2_prev_ff <= nxt_t2_prev;
            pe_prev_ff <= nxt_pe_prev;
            se_prev_ff <= nxt_se_prev;
        end
    end

    // Enable registers hold all eight bits; reserved ones read back only
    always_comb
    begin
        nxt_peripheral_irq_enable = peripheral_irq_enable_ff;
        nxt_main_enable = main_enable_ff;
        nxt_evt_mask = evt_mask_ff;
        if (wr_enable_hit)
        begin
            nxt_peripheral_irq_enable = wdata_in;
        end
        if (wr_main_hit)
        begin
            nxt_main_enable = wdata_in;
        end
        // Event mask only gates irq_out, never the group lines
        if (wr_evt_mask_hit)
        begin
            nxt_evt_mask = wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            peripheral_irq_enable_ff <= `PERIPHERAL_IRQ_ENABLE_RST;
            main_enable_ff <= `MAIN_IRQ_ENABLE_RST;
            evt_mask_ff <= `EVENT_MASK_RST;
        end
        else
        begin
            peripheral_irq_enable_ff <= nxt_peripheral_irq_enable;
            main_enable_ff <= nxt_main_enable;
            evt_mask_ff <= nxt_evt_mask;
        end
    end

    // Write one clears; a new edge in the same cycle wins over the clear
    always_comb
    begin
        nxt_pending = pending_ff;
        if (wr_pending_hit)
        begin
            nxt_pending = pending_ff & ~wdata_in;
        end
        // Reserved pending bits never set
        nxt_pending = (nxt_pending | rise) & `IMPL_MASK;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pending_ff <= `PENDING_RST;
        end
        else
        begin
            pending_ff <= nxt_pending;
        end
    end

    // Reserved enable bits masked off before use
    always_comb
    begin
        gated = pending_ff & peripheral_irq_enable_ff & `IMPL_MASK;
        timer_req = gated[`TIMER1_WRAP_BIT]
            | gated[`TIMER2_WRAP_BIT];
        periph_req = gated[`PERIPH_SRC_BIT];
        serial_req = gated[`SERIAL_SRC_BIT];
        // Main enable is the last gate, so a masked group drops in one cycle
        nxt_timer_grp = timer_req & main_enable_ff[`MAIN_TIMER_WRAP_BIT];
        nxt_periph_grp = periph_req & main_enable_ff[`MAIN_PERIPH_BIT];
        nxt_serial_grp = serial_req & main_enable_ff[`MAIN_SERIAL_BIT];
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            timer_grp_ff <= 1'b0;
            periph_grp_ff <= 1'b0;
            serial_grp_ff <= 1'b0;
        end
        else
        begin
            timer_grp_ff <= nxt_timer_grp;
            periph_grp_ff <= nxt_periph_grp;
            serial_grp_ff <= nxt_serial_grp;
        end
    end

    // Sticky status records each rising group line
    always_comb
    begin
        grp_evt = 8'h00;
        grp_evt[`EVT_TIMER_GROUP_BIT] = nxt_timer_grp & ~timer_grp_ff;
        grp_evt[`EVT_PERIPH_GROUP_BIT] = nxt_periph_grp & ~periph_grp_ff;
        grp_evt[`EVT_SERIAL_GROUP_BIT] = nxt_serial_grp & ~serial_grp_ff;
        nxt_evt_status = evt_status_ff;
        if (wr_status_hit)
        begin
            nxt_evt_status = evt_status_ff & ~wdata_in;
        end
        nxt_evt_status = (nxt_evt_status | grp_evt) & `EVT_IMPL_MASK;
        // Next values used so irq follows status on the same edge
        nxt_irq = |(nxt_evt_status & nxt_evt_mask);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            evt_status_ff <= `EVENT_STATUS_RST;
            irq_ff <= 1'b0;
        end
        else
        begin
            evt_status_ff <= nxt_evt_status;
            irq_ff <= nxt_irq;
        end
    end

    // Read data stands one cycle and is zero otherwise, so stale data never shows
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (rd_in)
        begin
            case (addr_in)
                `PERIPHERAL_IRQ_ENABLE_OFS: nxt_rdata = peripheral_irq_enable_ff;
                `PERIPHERAL_IRQ_PENDING_OFS: nxt_rdata = pending_ff;
                `MAIN_IRQ_ENABLE_OFS: nxt_rdata = main_enable_ff;
                `EVENT_STATUS_OFS: nxt_rdata = evt_status_ff;
                `EVENT_MASK_OFS: nxt_rdata = evt_mask_ff;
                // Unmapped addresses read as zero
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_out = rdata_ff;
    assign timer_wrap_group_irq_out = timer_grp_ff;
    assign peripheral_group_irq_out = periph_grp_ff;
    assign serial_group_irq_out = serial_grp_ff;
    assign irq_out = irq_ff;
endmodule : peripheral_interrupt_mask

// ===== src/pirq_map.svh
// Register offsets, field positions, reset values for the peripheral interrupt mask block
`ifndef PIRQ_MAP_SVH
`define PIRQ_MAP_SVH
`define ADDR_W 13
`define DATA_W 8
`define PERIPHERAL_IRQ_ENABLE_OFS 13'h1FBC
`define PERIPHERAL_IRQ_PENDING_OFS 13'h1FBE
`define MAIN_IRQ_ENABLE_OFS 13'h1FC0
`define EVENT_STATUS_OFS 13'h1FC2
`define EVENT_MASK_OFS 13'h1FC4
`define PERIPHERAL_IRQ_ENABLE_RST 8'hAA
`define PENDING_RST 8'h00
`define MAIN_IRQ_ENABLE_RST 8'h00
`define EVENT_STATUS_RST 8'h00
`define EVENT_MASK_RST 8'h00
`define TIMER1_WRAP_BIT 0
`define TIMER2_WRAP_BIT 2
`define PERIPH_SRC_BIT 4
`define SERIAL_SRC_BIT 6
`define MAIN_TIMER_WRAP_BIT 0
`define MAIN_PERIPH_BIT 1
`define MAIN_SERIAL_BIT 2
`define IMPL_MASK 8'h55
`define EVT_TIMER_GROUP_BIT 0
`define EVT_PERIPH_GROUP_BIT 1
`define EVT_SERIAL_GROUP_BIT 2
`define EVT_IMPL_MASK 8'h07
`endif

// ===== src/pirq_pkg.sv
// Types shared by the peripheral interrupt mask block
package pirq_pkg;
    typedef logic [7:0] reg8_t;
endpackage : pirq_pkg

// ===== src/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin
module pin_sync
    import pirq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic level_out
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;
    logic nxt_level;

    always_comb
    begin
        nxt_level = level_ff;
        // Accept change only once stages two and three agree
        if (s2_ff == s3_ff)
        begin
            nxt_level = s3_ff;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            level_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level_out = level_ff;
endmodule : pin_sync

// ===== tb/pirq_checker.sv
// Port-level assertions for the peripheral interrupt mask block
`include "pirq_map.svh"
module pirq_checker
    import pirq_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [`ADDR_W-1:0] addr_in,
    input wire logic [`DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [`DATA_W-1:0] rdata_out,
    input wire logic timer_wrap_group_irq_out,
    input wire logic peripheral_group_irq_out,
    input wire logic serial_group_irq_out
);
    // Shadow copies of the two enable registers, built from bus writes
    reg8_t en_ff;
    reg8_t main_ff;
    reg8_t nxt_en;
    reg8_t nxt_main;
    always_comb
    begin
        nxt_en = en_ff;
        nxt_main = main_ff;
        if (wr_in && addr_in == `PERIPHERAL_IRQ_ENABLE_OFS)
            nxt_en = wdata_in;
        if (wr_in && addr_in == `MAIN_IRQ_ENABLE_OFS)
            nxt_main = wdata_in;
    end
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            en_ff <= `PERIPHERAL_IRQ_ENABLE_RST;
            main_ff <= `MAIN_IRQ_ENABLE_RST;
        end
        else
        begin
            en_ff <= nxt_en;
            main_ff <= nxt_main;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    timer_rise_a: assert property ($rose(timer_wrap_group_irq_out)
        |-> main_ff[0] && (en_ff[0] || en_ff[2])) else $error("timer line rose while gated");
    periph_rise_a: assert property ($rose(peripheral_group_irq_out)
        |-> main_ff[1] && en_ff[4]) else $error("peripheral line rose while gated");
    serial_rise_a: assert property ($rose(serial_group_irq_out)
        |-> main_ff[2] && en_ff[6]) else $error("serial line rose while gated");
    main_gate_a: assert property ($fell(main_ff[0])
        |-> ##[1:2] !timer_wrap_group_irq_out) else $error("timer line kept after main off");
    timer1_gate_a: assert property ($fell(en_ff[0]) && !en_ff[2]
        |-> ##[1:2] !timer_wrap_group_irq_out) else $error("timer 1 not blocked");
    timer2_gate_a: assert property ($fell(en_ff[2]) && !en_ff[0]
        |-> ##[1:2] !timer_wrap_group_irq_out) else $error("timer 2 not blocked");
    mask_readback_a: assert property ($past(rd_in && addr_in == `PERIPHERAL_IRQ_ENABLE_OFS)
        |-> rdata_out == $past(en_ff)) else $error("mask read back wrong");
    cover property ($rose(timer_wrap_group_irq_out));
    cover property ($rose(peripheral_group_irq_out));
    cover property ($rose(serial_group_irq_out));
endmodule : pirq_checker

bind peripheral_interrupt_mask pirq_checker u_chk (.clk_sys_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .timer_wrap_group_irq_out, .peripheral_group_irq_out,
    .serial_group_irq_out);

// ===== tb/testbench.sv
// Self-checking bench for the peripheral interrupt mask block
`include "pirq_map.svh"
module testbench
    import pirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [`ADDR_W-1:0] addr_in = '0;
    reg8_t wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] ev = '0;
    reg8_t rdata_out;
    logic tg, pg, sg, irq_out;
    wire [3:0] grp = {sg, pg, tg, tg};
    int bad_count = 0;
    int samples_checked = 0;
    peripheral_interrupt_mask u_dut (.clk_sys_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .timer1_wrap_in(ev[0]), .timer2_wrap_in(ev[1]), .periph_event_in(ev[2]),
        .serial_event_in(ev[3]), .timer_wrap_group_irq_out(tg),
        .peripheral_group_irq_out(pg), .serial_group_irq_out(sg), .irq_out);
    initial
    begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input reg8_t seen, input reg8_t want);
        samples_checked++;
        if (seen !== want)
        begin
            bad_count++;
            $display("Error at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic wr(input logic [`ADDR_W-1:0] a, input reg8_t d);
        @(posedge clk_sys_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [`ADDR_W-1:0] a, input reg8_t want);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, want);
    endtask : rd
    // Pin held well past the synchroniser's agreement filter
    task automatic pulse(input int k);
        @(posedge clk_sys_in);
        ev[k] <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        ev[k] <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
    endtask : pulse
    task automatic settle;
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask : settle
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(`PERIPHERAL_IRQ_ENABLE_OFS, `PERIPHERAL_IRQ_ENABLE_RST);
        rd(13'h1FBA, 8'h00);
        wr(`EVENT_MASK_OFS, 8'h07);
        wr(`MAIN_IRQ_ENABLE_OFS, 8'h07);
        for (int k = 0; k < 4; k++)
        begin
            reg8_t b;
            reg8_t s;
            b = 8'h01 << (2 * k);
            s = (k < 2) ? 8'h01 : 8'h01 << (k - 1);
            wr(`PERIPHERAL_IRQ_ENABLE_OFS, 8'hAA);
            pulse(k);
            rd(`PERIPHERAL_IRQ_PENDING_OFS, b);
            chk(grp[k], 8'h00);
            wr(`PERIPHERAL_IRQ_ENABLE_OFS, 8'hAA | b);
            rd(`PERIPHERAL_IRQ_ENABLE_OFS, 8'hAA | b);
            settle();
            chk(grp[k], 8'h01);
            chk(irq_out, 8'h01);
            rd(`EVENT_STATUS_OFS, s);
            wr(`EVENT_STATUS_OFS, 8'h07);
            wr(`MAIN_IRQ_ENABLE_OFS, 8'h00);
            settle();
            chk(grp[k], 8'h00);
            wr(`EVENT_MASK_OFS, 8'h00);
            wr(`MAIN_IRQ_ENABLE_OFS, 8'h07);
            settle();
            chk(grp[k], 8'h01);
            chk(irq_out, 8'h00);
            wr(`EVENT_MASK_OFS, 8'h07);
            settle();
            chk(irq_out, 8'h01);
            wr(`PERIPHERAL_IRQ_ENABLE_OFS, 8'hAA);
            settle();
            chk(grp[k], 8'h00);
            wr(`PERIPHERAL_IRQ_PENDING_OFS, b);
            wr(`EVENT_STATUS_OFS, 8'h07);
            settle();
            chk(irq_out, 8'h00);
            $display("source %0d test done", k);
        end
        // Mid-run reset must bring the mask back to its reset value
        wr(`PERIPHERAL_IRQ_ENABLE_OFS, 8'h55);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(`PERIPHERAL_IRQ_ENABLE_OFS, `PERIPHERAL_IRQ_ENABLE_RST);
        $display("reset test done");
        print_verdict();
    end
endmodule : testbench
